// ==== dic_top.sv ====
/*
 Digital input conditioning and routing unit: samples five inputs on a
 1 ms tick, conditions or routes them into a 32-bit summary word.
 Assumes asynchronous pins and aux signals, plain register port master.
*/
`timescale 1ns/10ps
module dic_top (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic [dic_pkg::DIC_NUM_IN-1:0] pin_in,
    input wire dic_pkg::dic_aux_t aux_in,
    input wire dic_pkg::dic_bus_t bus_in,
    output logic [31:0] rdata_out,
    output logic [31:0] summary_out,
    output logic tick_out
);
    import dic_pkg::*;

    logic [15:0] tick_cnt;
    logic tick;
    logic [DIC_NUM_IN-1:0] pin_sync;
    dic_aux_t aux_sync;
    logic [31:0] sfe_mask;
    logic [31:0] pol_mask;
    logic [31:0] fen_mask;
    logic [31:0] fval_mask;
    logic [31:0] raw_val;
    logic [6:0] aux_raw;
    logic rt_en;
    logic [7:0] rtbl [DIC_NUM_SEL];
    logic [31:0] summary;
    logic [31:0] next_summary;
    logic [31:0] cond_val;
    logic sel_hit;
    logic [4:0] sel_idx;

    // ****************************************
    // Source decode
    // ****************************************
    function automatic logic dic_decode(input logic [7:0] code, input logic [31:0] phys, input logic [6:0] aux);
        logic base;
        logic known;
        base = 1'b0;
        known = 1'b1;
        if (code[6:0] >= DIC_SRC_PHYS_LO && code[6:0] <= DIC_SRC_PHYS_HI)
        begin
            base = phys[5'(code[6:0] - DIC_SRC_PHYS_LO)];
        end
        else if (code[6:0] >= DIC_SRC_HALL_U && code[6:0] <= DIC_SRC_USB)
        begin
            base = aux[3'(DIC_SRC_USB - code[6:0])];
        end
        else if (code[6:0] != DIC_SRC_ZERO[6:0])
        begin
            known = 1'b0;
        end
        return known & (base ^ code[DIC_SRC_INV_BIT]);
    endfunction : dic_decode

    // ****************************************
    // Input synchronisers
    // ****************************************
    dic_sync #(.WIDTH(DIC_NUM_IN)) u_pin_sync (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    dic_sync #(.WIDTH(7)) u_aux_sync (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .async_in(aux_in),
        .sync_out(aux_sync)
    );

    // ****************************************
    // Sampling tick divider
    // ****************************************
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            tick_cnt <= 16'h0000;
        end
        else if (tick_cnt == DIC_TICK_LAST)
        begin
            tick_cnt <= 16'h0000;
        end
        else
        begin
            tick_cnt <= tick_cnt + 16'h0001;
        end
    end

    assign tick = (tick_cnt == DIC_TICK_LAST);
    assign tick_out = tick;

    // ****************************************
    // Raw sample register
    // ****************************************
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            raw_val <= 32'h0000_0000;
            aux_raw <= 7'h00;
        end
        else if (tick)
        begin
            raw_val <= {{(32-DIC_NUM_IN){1'b0}}, pin_sync};
            aux_raw <= aux_sync;
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            sfe_mask <= DIC_RST_MASK;
            pol_mask <= DIC_RST_MASK;
            fen_mask <= DIC_RST_MASK;
            fval_mask <= DIC_RST_MASK;
            rt_en <= 1'b0;
        end
        else if (bus_in.wr)
        begin
            unique case (bus_in.addr)
                DIC_ADDR_SFE: sfe_mask <= bus_in.wdata;
                DIC_ADDR_POL: pol_mask <= bus_in.wdata;
                DIC_ADDR_FEN: fen_mask <= bus_in.wdata;
                DIC_ADDR_FVAL: fval_mask <= bus_in.wdata;
                DIC_ADDR_RTEN: rt_en <= bus_in.wdata[0];
                default: ;
            endcase
        end
    end

    assign sel_hit = (bus_in.addr & DIC_RTBL_MASK) == DIC_RTBL_BASE;
    assign sel_idx = bus_in.addr[DIC_RTBL_IDX_LSB +: 5];

    // ****************************************
    // Routing table with entry defaults
    // ****************************************
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            for (int k = 0; k < DIC_NUM_SEL; k++)
            begin
                rtbl[k] <= DIC_RST_SRC;
            end
        end
        else if (bus_in.wr && bus_in.addr == DIC_ADDR_RTEN && bus_in.wdata[0] && !rt_en)
        begin
            for (int k = 0; k < DIC_NUM_SEL; k++)
            begin
                rtbl[k] <= DIC_SRC_ZERO;
            end
            for (int i = 0; i < DIC_NUM_IN; i++)
            begin
                rtbl[i] <= (sfe_mask[i] && !fen_mask[i]) ? {pol_mask[i], 7'(i + 1)} : (fen_mask[i]
                    ? {(fval_mask[i] ^ pol_mask[i]) & sfe_mask[i], 7'h00} : DIC_SRC_ZERO);
                rtbl[i + DIC_LEVEL_LSB] <= fen_mask[i] ? {fval_mask[i] ^ pol_mask[i], 7'h00}
                    : {pol_mask[i], 7'(i + 1)};
            end
        end
        else if (bus_in.wr && sel_hit)
        begin
            rtbl[sel_idx] <= bus_in.wdata[7:0];
        end
    end

    // ****************************************
    // Summary computation
    // ****************************************
    always_comb
    begin
        next_summary = 32'h0000_0000;
        cond_val = (raw_val & ~fen_mask) | (fval_mask & fen_mask);
        cond_val = cond_val ^ pol_mask;
        if (rt_en)
        begin
            for (int k = 0; k < DIC_NUM_SEL; k++)
            begin
                next_summary[k] = dic_decode(rtbl[k], raw_val, aux_raw);
            end
        end
        else
        begin
            for (int i = 0; i < DIC_NUM_IN; i++)
            begin
                next_summary[i] = cond_val[i] & sfe_mask[i];
                next_summary[i + DIC_LEVEL_LSB] = cond_val[i];
            end
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            summary <= 32'h0000_0000;
        end
        else if (tick)
        begin
            summary <= next_summary;
        end
    end

    assign summary_out = summary;

    // ****************************************
    // Read port
    // ****************************************
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            rdata_out <= 32'h0000_0000;
        end
        else if (bus_in.rd)
        begin
            if (sel_hit)
            begin
                rdata_out <= {24'h00_0000, rtbl[sel_idx]};
            end
            else
            begin
                unique case (bus_in.addr)
                    DIC_ADDR_SFE: rdata_out <= sfe_mask;
                    DIC_ADDR_POL: rdata_out <= pol_mask;
                    DIC_ADDR_FEN: rdata_out <= fen_mask;
                    DIC_ADDR_FVAL: rdata_out <= fval_mask;
                    DIC_ADDR_RAW: rdata_out <= raw_val;
                    DIC_ADDR_RTEN: rdata_out <= {31'h0000_0000, rt_en};
                    DIC_ADDR_SUM: rdata_out <= summary;
                    default: rdata_out <= 32'h0000_0000;
                endcase
            end
        end
        else
        begin
            rdata_out <= 32'h0000_0000;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_summary_tick;
        @(posedge sys_clk_in) disable iff (srst_in)
        !$past(tick) |-> $stable(summary);
    endproperty
    a_summary_tick: assert property (p_summary_tick) else $error("summary changed off tick");

    property p_raw_hold;
        @(posedge sys_clk_in) disable iff (srst_in)
        !$past(tick) |-> $stable(raw_val);
    endproperty
    a_raw_hold: assert property (p_raw_hold) else $error("raw changed off tick");

    property p_upper_zero;
        @(posedge sys_clk_in) disable iff (srst_in)
        !rt_en |-> next_summary[31:21] == 11'h000 && next_summary[15:5] == 11'h000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("unused summary bits set");

    property p_sfe_gate;
        @(posedge sys_clk_in) disable iff (srst_in)
        !rt_en && !sfe_mask[DIC_BIT_NEG_LIM] |-> !next_summary[DIC_BIT_NEG_LIM];
    endproperty
    a_sfe_gate: assert property (p_sfe_gate) else $error("special bit not gated");

    property p_level_free;
        @(posedge sys_clk_in) disable iff (srst_in)
        !rt_en |-> next_summary[DIC_LEVEL_LSB] == ((fen_mask[0] ? fval_mask[0] : raw_val[0]) ^ pol_mask[0]);
    endproperty
    a_level_free: assert property (p_level_free) else $error("level bit wrong");

    property p_force;
        @(posedge sys_clk_in) disable iff (srst_in)
        !rt_en && fen_mask[DIC_BIT_NEG_LIM] && sfe_mask[DIC_BIT_NEG_LIM]
            |-> next_summary[DIC_BIT_NEG_LIM] == (fval_mask[DIC_BIT_NEG_LIM] ^ pol_mask[DIC_BIT_NEG_LIM]);
    endproperty
    a_force: assert property (p_force) else $error("forced value ignored");

    property p_route_zero;
        @(posedge sys_clk_in) disable iff (srst_in)
        rt_en && rtbl[DIC_BIT_POS_LIM] == DIC_SRC_ZERO |-> !next_summary[DIC_BIT_POS_LIM];
    endproperty
    a_route_zero: assert property (p_route_zero) else $error("code zero not zero");

    property p_route_one;
        @(posedge sys_clk_in) disable iff (srst_in)
        rt_en && rtbl[0] == 8'h80 |-> next_summary[0];
    endproperty
    a_route_one: assert property (p_route_one) else $error("code 80 not one");

    property p_route_level;
        @(posedge sys_clk_in) disable iff (srst_in)
        rt_en && rtbl[DIC_LEVEL_LSB + DIC_BIT_HOME] == 8'h03
            |-> next_summary[DIC_LEVEL_LSB + DIC_BIT_HOME] == raw_val[DIC_BIT_HOME];
    endproperty
    a_route_level: assert property (p_route_level) else $error("physical source not routed");

    sequence s_route_on;
        bus_in.wr && bus_in.addr == DIC_ADDR_RTEN && bus_in.wdata[0] && !rt_en && !fen_mask[DIC_BIT_POS_LIM];
    endsequence

    property p_route_entry;
        @(posedge sys_clk_in) disable iff (srst_in)
        s_route_on |=> rt_en && rtbl[DIC_LEVEL_LSB + DIC_BIT_POS_LIM] == {$past(pol_mask[DIC_BIT_POS_LIM]), 7'h02};
    endproperty
    a_route_entry: assert property (p_route_entry) else $error("routing defaults not loaded");

    property p_read_lat;
        @(posedge sys_clk_in) disable iff (srst_in)
        bus_in.rd && bus_in.addr == DIC_ADDR_SUM |=> rdata_out == $past(summary);
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("summary read wrong");
endmodule : dic_top

// ==== dic_pkg.sv ====
/*
 Package for the digital input conditioning block: register map, field
 positions, reset values, source codes and tick timing.
 Assumes a 50 MHz system clock and a plain register port.
*/
package dic_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] DIC_ADDR_SFE = 8'h00;
    localparam logic [7:0] DIC_ADDR_POL = 8'h04;
    localparam logic [7:0] DIC_ADDR_FEN = 8'h08;
    localparam logic [7:0] DIC_ADDR_FVAL = 8'h0C;
    localparam logic [7:0] DIC_ADDR_RAW = 8'h10;
    localparam logic [7:0] DIC_ADDR_RTEN = 8'h14;
    localparam logic [7:0] DIC_ADDR_SUM = 8'h18;
    localparam logic [7:0] DIC_ADDR_RTBL = 8'h80;
    localparam logic [7:0] DIC_RTBL_MASK = 8'h80;
    localparam logic [7:0] DIC_RTBL_BASE = 8'h80;
    localparam int DIC_RTBL_IDX_LSB = 2;
    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int DIC_NUM_IN = 5;
    localparam int DIC_NUM_SEL = 32;
    localparam int DIC_LEVEL_LSB = 16;
    localparam int DIC_BIT_NEG_LIM = 0;
    localparam int DIC_BIT_POS_LIM = 1;
    localparam int DIC_BIT_HOME = 2;
    localparam logic [31:0] DIC_RST_MASK = 32'h0000_0000;
    localparam logic [7:0] DIC_RST_SRC = 8'h00;
    // ****************************************
    // Source codes
    // ****************************************
    localparam logic [7:0] DIC_SRC_ZERO = 8'h00;
    localparam logic [6:0] DIC_SRC_PHYS_LO = 7'h01;
    localparam logic [6:0] DIC_SRC_PHYS_HI = 7'h10;
    localparam logic [6:0] DIC_SRC_HALL_U = 7'h41;
    localparam logic [6:0] DIC_SRC_HALL_V = 7'h42;
    localparam logic [6:0] DIC_SRC_HALL_W = 7'h43;
    localparam logic [6:0] DIC_SRC_ENC_A = 7'h44;
    localparam logic [6:0] DIC_SRC_ENC_B = 7'h45;
    localparam logic [6:0] DIC_SRC_ENC_I = 7'h46;
    localparam logic [6:0] DIC_SRC_USB = 7'h47;
    localparam int DIC_SRC_INV_BIT = 7;
    // ****************************************
    // Timing
    // ****************************************
    localparam int DIC_CLK_HZ = 50_000_000;
    localparam int DIC_TICK_US = 1000;
    localparam int DIC_TICK_CYC = DIC_CLK_HZ / 1_000_000 * DIC_TICK_US;
    localparam logic [15:0] DIC_TICK_LAST = 16'(DIC_TICK_CYC - 1);

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dic_bus_t;

    typedef struct packed {
        logic hall_u;
        logic hall_v;
        logic hall_w;
        logic enc_a;
        logic enc_b;
        logic enc_i;
        logic usb;
    } dic_aux_t;
endpackage : dic_pkg

// ==== dic_sync.sv ====
/*
 Three-stage synchroniser with agreement filter for asynchronous inputs.
 Assumes one system clock; output changes when stages two and three agree.
*/
`timescale 1ns/10ps
module dic_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // ****************************************
    // Synchroniser chain
    // ****************************************
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end
        else
        begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // ****************************************
    // Agreement filter
    // ****************************************
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            sync_out <= '0;
        end
        else
        begin
            for (int i = 0; i < WIDTH; i++)
            begin
                if (stage2[i] == stage3[i])
                begin
                    sync_out[i] <= stage3[i];
                end
            end
        end
    end
endmodule : dic_sync

// ==== dic_sensor_model.sv ====
/*
 Model of the switches and sensors on the input pins: steady levels set by
 the bench, plus a short pulse on input 3 that ends well within one tick.
 Assumes the bench holds levels steady except for the commanded pulse.
*/
`timescale 1ns/10ps
module dic_sensor_model (
    input wire logic sys_clk_in,
    input wire logic [dic_pkg::DIC_NUM_IN-1:0] level_in,
    input wire dic_pkg::dic_aux_t aux_level_in,
    input wire logic glitch_in,
    output logic [dic_pkg::DIC_NUM_IN-1:0] pin_out,
    output dic_pkg::dic_aux_t aux_out
);
    import dic_pkg::*;
    int pulse_left = 0;

    // ****************************************
    // Short pulse, 100 cycles
    // ****************************************
    always @(posedge sys_clk_in)
    begin
        if (glitch_in)
            pulse_left <= 100;
        else if (pulse_left > 0)
            pulse_left <= pulse_left - 1;
    end

    always_comb
    begin
        pin_out = level_in;
        pin_out[3] = level_in[3] ^ (pulse_left > 0);
        aux_out = aux_level_in;
    end
endmodule : dic_sensor_model

// ==== testbench.sv ====
/*
 Self-checking bench for the input conditioning block: register port
 tasks, normal mode check at the first tick, routing check at the second.
 Assumes the fixed 50000-cycle tick and the register offsets of dic_pkg.
*/
`timescale 1ns/10ps
module testbench;
    import dic_pkg::*;
    localparam logic [31:0] ROUTED = 32'hFFE0_FFF8;
    localparam logic [7:0] CODES [0:31] = '{8'h00, 8'h00, 8'h00, 8'hA0, 8'h02, 8'h06, 8'h41, 8'h42,
        8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h80, 8'h81, 8'hC1, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'h20, 8'h90, 8'h10, 8'h01, 8'h05};
    localparam logic [7:0] CFG_ADDR [0:3] = '{DIC_ADDR_SFE, DIC_ADDR_POL, DIC_ADDR_FEN, DIC_ADDR_FVAL};
    localparam logic [31:0] CFG_VAL [0:3] = '{32'h0000_0005, 32'h0000_0002, 32'h0000_0011, 32'h0000_0001};
    logic sys_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [4:0] level = 5'h16;
    dic_aux_t aux_level = 7'h55;
    logic glitch = 1'b0;
    logic [4:0] pin;
    dic_aux_t aux;
    dic_bus_t bus = '0;
    logic [31:0] rdata;
    logic [31:0] summary;
    logic [31:0] prior;
    logic [31:0] exp_sum;
    logic tick;
    int fails = 0;
    int n_checks = 0;

    always #10 sys_clk_in = ~sys_clk_in;

    dic_sensor_model u_dic_sensor_model (.sys_clk_in(sys_clk_in), .level_in(level),
        .aux_level_in(aux_level), .glitch_in(glitch), .pin_out(pin), .aux_out(aux));
    dic_top u_dic_top (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .pin_in(pin), .aux_in(aux),
        .bus_in(bus), .rdata_out(rdata), .summary_out(summary), .tick_out(tick));

    // ****************************************
    // Tasks and expectations
    // ****************************************
    task automatic close_out;
        if (fails == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge sys_clk_in);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk_in);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge sys_clk_in);
        bus.rd <= 1'b0;
        @(negedge sys_clk_in);
        chk(rdata, exp);
    endtask : rd

    task automatic wait_tick;
        int n;
        n = 0;
        @(negedge sys_clk_in);
        while (tick !== 1'b1 && n < 60000)
        begin
            @(negedge sys_clk_in);
            n++;
        end
        if (tick !== 1'b1)
        begin
            $display("mismatch at %0t: no sampling tick", $time);
            fails++;
        end
        @(posedge sys_clk_in);
        @(negedge sys_clk_in);
    endtask : wait_tick

    function automatic logic [31:0] exp_norm(input logic [4:0] r, input logic [4:0] sfe, input logic [4:0] pol,
        input logic [4:0] fen, input logic [4:0] fval);
        logic [4:0] c;
        c = ((fen & fval) | (~fen & r)) ^ pol;
        return {11'h000, c, 11'h000, c & sfe};
    endfunction : exp_norm

    function automatic logic route_bit(input logic [7:0] c, input logic [4:0] r, input logic [6:0] a);
        logic v;
        logic k;
        v = 1'b0;
        k = (c[6:0] <= 7'h10) || (c[6:0] >= 7'h41 && c[6:0] <= 7'h47);
        if (c[6:0] >= 7'h01 && c[6:0] <= 7'h05)
            v = r[c[2:0] - 3'h1];
        if (c[6:0] >= 7'h41 && c[6:0] <= 7'h47)
            v = a[3'h7 - c[2:0]];
        return k & (v ^ c[7]);
    endfunction : route_bit

    // ****************************************
    // Watchdog and main sequence
    // ****************************************
    initial
    begin
        repeat (2 * DIC_TICK_CYC + 1000) @(posedge sys_clk_in);
        $display("mismatch at %0t: watchdog expired", $time);
        fails++;
        close_out();
    end

    initial
    begin
        repeat (20) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        rd(DIC_ADDR_SFE, DIC_RST_MASK);
        rd(DIC_ADDR_RAW, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        for (int i = 0; i < 4; i++)
        begin
            wr(CFG_ADDR[i], CFG_VAL[i]);
            rd(CFG_ADDR[i], CFG_VAL[i]);
        end
        wait_tick();
        prior = exp_norm(5'h00, 5'h05, 5'h02, 5'h11, 5'h01);
        chk(summary, prior);
        rd(DIC_ADDR_SUM, prior);
        rd(DIC_ADDR_RAW, 32'h0000_0016);
        wr(DIC_ADDR_RAW, 32'hFFFF_FFFF);
        rd(DIC_ADDR_RAW, 32'h0000_0016);
        @(posedge sys_clk_in);
        glitch <= 1'b1;
        @(posedge sys_clk_in);
        glitch <= 1'b0;
        prior = exp_norm(5'h16, 5'h05, 5'h02, 5'h11, 5'h01);
        wr(DIC_ADDR_RTEN, 32'h0000_0001);
        wr(DIC_ADDR_POL, 32'h0000_001F);
        wr(DIC_ADDR_FEN, 32'h0000_0000);
        for (int j = 0; j < 32; j++)
            if (ROUTED[j])
                wr(DIC_ADDR_RTBL + 8'(4 * j), {24'h00_0000, CODES[j]});
        rd(DIC_ADDR_RTBL + 8'h10, 32'h0000_0002);
        rd(DIC_ADDR_RTEN, 32'h0000_0001);
        wait_tick();
        rd(DIC_ADDR_RAW, 32'h0000_0016);
        for (int j = 0; j < 32; j++)
            exp_sum[j] = ROUTED[j] ? route_bit(CODES[j], 5'h16, aux_level) : prior[j];
        chk(summary, exp_sum);
        close_out();
    end
endmodule : testbench
